// file: design/pes_event_decoder.sv
// Summary of operation
// RL1: Code C0H counts retired instructions.
// RL2: Code C2H counts retired micro-operations.
// RL3: Code D0H counts decoded instructions.
// RL4: Code C8H counts received hardware interrupts.
// RL5: Code C4H counts retired branches.
// RL6: Code C9H counts retired taken branches.
// RL7: Code E0H counts branches at decode.
// RL8: Code E2H counts branch target buffer misses.
// RL9: Code E4H counts spurious branch predictions.
// RL10: Code 04H counts store queue drain cycles.
// RL11: Code 06H counts segment register loads.
// RL12: Cache events filtered by qualifier state bits.
// RL13: Filter FH counts all, 0H counts nothing.
// RL14: Qualifier bit 5 selects self or any agent.
// RL15: Code 7:0, qualifier 15:8, enable bit 22.
// RL16: Counter adds one per qualifying cycle.
`default_nettype none
module pes_event_decoder (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire pes_pkg::pes_event_type    events_in,
  output logic                           counting_enabled
);

  pes_pkg::pes_bus_state_type state_reg;
  pes_pkg::pes_bus_state_type state_next;
  logic [pes_pkg::ADDR_W-1:0] addr_reg;
  logic [pes_pkg::DATA_W-1:0] hrdata_reg;
  logic [pes_pkg::DATA_W-1:0] sel_reg   [pes_pkg::NUM_COUNTERS];
  logic [pes_pkg::DATA_W-1:0] count_reg [pes_pkg::NUM_COUNTERS];
  logic [pes_pkg::NUM_COUNTERS-1:0] wr_sel;
  logic [pes_pkg::NUM_COUNTERS-1:0] wr_count;
  logic [pes_pkg::NUM_COUNTERS-1:0] hit;
  logic                       accept;
  logic                       write_phase;
  logic                       hit_sel_zero;
  logic                       hit_sel_one;
  logic                       hit_count_zero;
  logic                       hit_count_one;
  logic [pes_pkg::DATA_W-1:0] read_value;

  // Increment condition for one counter from its select word
  function automatic logic pes_hit(input logic [31:0] sel,
                                   input pes_pkg::pes_event_type ev);
    logic [7:0] code;
    logic [7:0] qual;
    logic       result;
    code   = sel[pes_pkg::CODE_MSB:pes_pkg::CODE_LSB];  // see RL15
    qual   = sel[pes_pkg::QUAL_MSB:pes_pkg::QUAL_LSB];  // see RL15
    result = 1'b0;
    case (code)
      pes_pkg::CODE_RETIRED_INSTR:   result = ev.retired_instruction_event;  // see RL1
      pes_pkg::CODE_RETIRED_MICROOP: result = ev.retired_microop_event;  // see RL2
      pes_pkg::CODE_DECODED_INSTR:   result = ev.decoded_instruction_event;  // see RL3
      pes_pkg::CODE_HW_INTERRUPT:
        result = ev.hardware_interrupt_received_event;  // see RL4
      pes_pkg::CODE_RETIRED_BRANCH:  result = ev.retired_branch_event;  // see RL5
      pes_pkg::CODE_RETIRED_TAKEN:   result = ev.retired_taken_branch_event;  // see RL6
      pes_pkg::CODE_DECODED_BRANCH:  result = ev.decoded_branch_event;  // see RL7
      pes_pkg::CODE_TARGET_MISS:     result = ev.branch_target_miss_event;  // see RL8
      pes_pkg::CODE_SPURIOUS_BRANCH: result = ev.spurious_branch_event;  // see RL9
      pes_pkg::CODE_STORE_DRAIN:     result = ev.store_queue_drain_event;  // see RL10
      pes_pkg::CODE_SEGMENT_LOAD:    result = ev.segment_load_event;  // see RL11
      // One-hot line state against the state filter
      pes_pkg::CODE_CACHE_ACCESS:
        result = ev.cache_access_event
                 && |(qual[pes_pkg::STATE_MSB:0] & ev.cache_line_state);  // see RL12 RL13
      // Scope bit clear restricts to own transactions
      pes_pkg::CODE_BUS_TRANSACTION:
        result = ev.bus_transaction_event
                 && (qual[pes_pkg::SCOPE_BIT] || ev.bus_transaction_self);  // see RL14
      default: result = 1'b0;
    endcase
    return result;
  endfunction

  // Bus front end: writes take no wait state, reads take one
  assign accept      = hsel && hready && (htrans == pes_pkg::HTRANS_NONSEQ || htrans[1]);
  assign write_phase = (state_reg == pes_pkg::BUS_WRITE);

  assign hit_sel_zero   = (addr_reg == pes_pkg::SEL_ZERO_OFFSET);
  assign hit_sel_one    = (addr_reg == pes_pkg::SEL_ONE_OFFSET);
  assign hit_count_zero = (addr_reg == pes_pkg::COUNT_ZERO_OFFSET);
  assign hit_count_one  = (addr_reg == pes_pkg::COUNT_ONE_OFFSET);

  assign wr_sel[0]   = write_phase && hit_sel_zero;
  assign wr_sel[1]   = write_phase && hit_sel_one;
  assign wr_count[0] = write_phase && hit_count_zero;
  assign wr_count[1] = write_phase && hit_count_one;

  assign read_value = hit_sel_zero   ? sel_reg[0]   :
                      hit_sel_one    ? sel_reg[1]   :
                      hit_count_zero ? count_reg[0] :
                      hit_count_one  ? count_reg[1] :
                      pes_pkg::UNMAPPED_READ;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pes_pkg::BUS_READ_WAIT: state_next = pes_pkg::BUS_READ_DONE;
      default: begin
        if (accept) begin
          state_next = hwrite ? pes_pkg::BUS_WRITE : pes_pkg::BUS_READ_WAIT;
        end else begin
          state_next = pes_pkg::BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= pes_pkg::BUS_IDLE;
      addr_reg  <= '0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        addr_reg <= haddr[pes_pkg::ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (state_reg == pes_pkg::BUS_READ_WAIT) begin
      hrdata_reg <= read_value;
    end
  end

  assign hreadyout = (state_reg != pes_pkg::BUS_READ_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // Only the first select word gates both counters
  assign counting_enabled = sel_reg[0][pes_pkg::ENABLE_BIT];  // see RL15

  for (genvar i = 0; i < pes_pkg::NUM_COUNTERS; i++) begin : g_counter
    assign hit[i] = pes_hit(sel_reg[i], events_in);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sel_reg[i] <= pes_pkg::SEL_RESET;
      end else if (wr_sel[i]) begin
        sel_reg[i] <= hwdata;
      end
    end

    // Software write takes priority over a same-cycle increment
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        count_reg[i] <= pes_pkg::COUNT_RESET;
      end else if (wr_count[i]) begin
        count_reg[i] <= hwdata;
      end else if (counting_enabled && hit[i]) begin
        count_reg[i] <= count_reg[i] + 32'h0000_0001;  // see RL16
      end
    end
  end

endmodule // pes_event_decoder
`default_nettype wire

// file: design/pes_pkg.sv
`default_nettype none
package pes_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_COUNTERS = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] SEL_ZERO_OFFSET  = 8'h00;
  localparam logic [ADDR_W-1:0] SEL_ONE_OFFSET   = 8'h04;
  localparam logic [ADDR_W-1:0] COUNT_ZERO_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] COUNT_ONE_OFFSET  = 8'h0C;

  // Event-select field layout
  localparam int unsigned CODE_LSB    = 0;
  localparam int unsigned CODE_MSB    = 7;
  localparam int unsigned QUAL_LSB    = 8;
  localparam int unsigned QUAL_MSB    = 15;
  localparam int unsigned ENABLE_BIT  = 22;
  localparam int unsigned SCOPE_BIT   = 5;
  localparam int unsigned STATE_MSB   = 3;

  // Reset values and unmapped read value
  localparam logic [DATA_W-1:0] SEL_RESET   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  // Event codes
  localparam logic [7:0] CODE_RETIRED_INSTR   = 8'hC0;
  localparam logic [7:0] CODE_RETIRED_MICROOP = 8'hC2;
  localparam logic [7:0] CODE_DECODED_INSTR   = 8'hD0;
  localparam logic [7:0] CODE_HW_INTERRUPT    = 8'hC8;
  localparam logic [7:0] CODE_RETIRED_BRANCH  = 8'hC4;
  localparam logic [7:0] CODE_RETIRED_TAKEN   = 8'hC9;
  localparam logic [7:0] CODE_DECODED_BRANCH  = 8'hE0;
  localparam logic [7:0] CODE_TARGET_MISS     = 8'hE2;
  localparam logic [7:0] CODE_SPURIOUS_BRANCH = 8'hE4;
  localparam logic [7:0] CODE_STORE_DRAIN     = 8'h04;
  localparam logic [7:0] CODE_SEGMENT_LOAD    = 8'h06;
  localparam logic [7:0] CODE_CACHE_ACCESS    = 8'h28;
  localparam logic [7:0] CODE_BUS_TRANSACTION = 8'h70;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic       retired_instruction_event;
    logic       retired_microop_event;
    logic       decoded_instruction_event;
    logic       hardware_interrupt_received_event;
    logic       retired_branch_event;
    logic       retired_taken_branch_event;
    logic       decoded_branch_event;
    logic       branch_target_miss_event;
    logic       spurious_branch_event;
    logic       store_queue_drain_event;
    logic       segment_load_event;
    logic       cache_access_event;
    logic [3:0] cache_line_state;
    logic       bus_transaction_event;
    logic       bus_transaction_self;
  } pes_event_type;

  typedef enum logic [1:0] {
    BUS_IDLE      = 2'b00,
    BUS_WRITE     = 2'b01,
    BUS_READ_WAIT = 2'b10,
    BUS_READ_DONE = 2'b11
  } pes_bus_state_type;
endpackage
`default_nettype wire

// file: tb/pes_event_decoder_chk.sv
`default_nettype none
module pes_event_decoder_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        counting_enabled
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic take;
  wire logic sel0_wr;
  assign take = hsel & hready & htrans[1];
  assign sel0_wr = take & hwrite & (haddr[7:0] == pes_pkg::SEL_ZERO_OFFSET);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_resp_okay:
    assert property (hresp == 1'b0) else $error("hresp not okay");
  chk_read_wait:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
  chk_write_fast:
    assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  chk_wait_cause:
    assert property (!hreadyout |-> $past(take && !hwrite)) else $error("stray wait");
  chk_wait_single:
    assert property (!hreadyout |=> hreadyout) else $error("wait too long");
  chk_rdata_hold:
    assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
  chk_enable_set:
    assert property (sel0_wr |=> ##1 counting_enabled == $past(hwdata[pes_pkg::ENABLE_BIT]))
      else $error("enable not loaded");
  chk_enable_only:
    assert property ($changed(counting_enabled) |-> $past(sel0_wr, 2)) else $error("enable moved");
endmodule // pes_event_decoder_chk
`default_nettype wire

// file: tb/pes_event_decoder_tb_top.sv
`default_nettype none
module pes_event_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   hclk, hresetn, hsel, hwrite, hreadyout, hresp, counting_enabled;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [31:0]            haddr, hwdata, hrdata;
  pes_pkg::pes_event_type events_in;
  int                     n_errors, checks;

  pes_event_decoder u_pes_event_decoder (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .events_in(events_in),
    .counting_enabled(counting_enabled)
  );

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask

  // Samples at the falling edge, returns on the next rising edge
  task automatic wait_rdy(output logic [31:0] q);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      close_out();
    end
    q = hrdata;
    @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= pes_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy(q);
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(q);
  endtask

  task automatic pulse(input pes_pkg::pes_event_type e);
    events_in <= e;
    @(posedge hclk);
    events_in <= '0;
    @(posedge hclk);
  endtask

  // First pulse lands while disabled and must not count
  task automatic count_case(input logic [31:0] s0, input logic [31:0] s1,
                            input pes_pkg::pes_event_type a, input pes_pkg::pes_event_type b,
                            input logic [31:0] e0, input logic [31:0] e1);
    logic [31:0] q;
    bus(1'b1, pes_pkg::SEL_ZERO_OFFSET, s0, q);
    bus(1'b1, pes_pkg::SEL_ONE_OFFSET, s1, q);
    bus(1'b1, pes_pkg::COUNT_ZERO_OFFSET, 32'h0000_0000, q);
    bus(1'b1, pes_pkg::COUNT_ONE_OFFSET, 32'h0000_0000, q);
    pulse(a);
    bus(1'b1, pes_pkg::SEL_ZERO_OFFSET, s0 | 32'h0040_0000, q);
    pulse(a);
    pulse(b);
    bus(1'b1, pes_pkg::SEL_ZERO_OFFSET, s0, q);
    bus(1'b0, pes_pkg::COUNT_ZERO_OFFSET, 32'h0000_0000, q);
    chk("count zero", q, e0);
    bus(1'b0, pes_pkg::COUNT_ONE_OFFSET, 32'h0000_0000, q);
    chk("count one", q, e1);
  endtask

  task automatic sc_regs;
    logic [31:0] q;
    for (int a = 0; a < 20; a += 4) begin
      bus(1'b0, 8'(a), 32'h0000_0000, q);
      chk("reset value", q, 32'h0000_0000);
    end
    bus(1'b1, 8'h10, 32'hFFFF_FFFF, q);
    bus(1'b0, 8'h10, 32'h0000_0000, q);
    chk("unmapped", q, 32'h0000_0000);
    bus(1'b1, pes_pkg::SEL_ONE_OFFSET, 32'hFFFF_FFFF, q);
    bus(1'b0, pes_pkg::SEL_ONE_OFFSET, 32'h0000_0000, q);
    chk("select one", q, 32'hFFFF_FFFF);
    chk("enable", {31'h0, counting_enabled}, 32'h0000_0000);
  endtask

  task automatic sc_event_codes;
    logic [7:0] code [11] = '{8'hC0, 8'hC2, 8'hD0, 8'hC8, 8'hC4, 8'hC9, 8'hE0, 8'hE2,
                              8'hE4, 8'h04, 8'h06};
    pes_pkg::pes_event_type ev;
    for (int i = 0; i < 11; i++) begin
      ev = '0;
      ev[17-i] = 1'b1;
      count_case({24'h0, code[i]}, {24'h0, code[(i+1)%11]}, ev, ev, 32'h2, 32'h0);
    end
  endtask

  task automatic sc_cache_filter;
    pes_pkg::pes_event_type m, v;
    m = '0;
    m.cache_access_event = 1'b1;
    v = m;
    m.cache_line_state = 4'h8;
    v.cache_line_state = 4'h1;
    count_case(32'h0000_0828, 32'h0000_0128, m, v, 32'h1, 32'h1);
    count_case(32'h0000_0F28, 32'h0000_0028, m, v, 32'h2, 32'h0);
    count_case(32'h0000_0428, 32'h0000_0628, m, v, 32'h0, 32'h0);
  endtask

  task automatic sc_bus_scope;
    pes_pkg::pes_event_type s, o;
    s = '0;
    s.bus_transaction_event = 1'b1;
    o = s;
    s.bus_transaction_self = 1'b1;
    count_case(32'h0000_0070, 32'h0000_2070, s, o, 32'h1, 32'h2);
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    events_in = '0;
    n_errors = 0;
    checks = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    sc_regs();
    sc_event_codes();
    sc_cache_filter();
    sc_bus_scope();
    close_out();
  end
endmodule // pes_event_decoder_tb_top

bind pes_event_decoder pes_event_decoder_chk u_pes_event_decoder_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .counting_enabled(counting_enabled)
);
`default_nettype wire
